// File: shared/fdc_ctrl_defines.svh
// offsets, field positions, reset values and timing counts of the control-command block
`ifndef FDC_CTRL_DEFINES_SVH
`define FDC_CTRL_DEFINES_SVH
`define CLK_MHZ 50
`define TIME_UNIT_US 250
`define UNIT_CYC (`TIME_UNIT_US * `CLK_MHZ)
`define STEP_PULSE_NS 1000
`define STEP_PULSE_CYC ((`STEP_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define HUT_ZERO_MS 64
`define HUT_STEP_MS 4
`define HLT_ZERO_MS 64
`define HLT_STEP_US 500
`define HUT_ZERO_UNITS (`HUT_ZERO_MS * 1000 / `TIME_UNIT_US)
`define HUT_STEP_UNITS (`HUT_STEP_MS * 1000 / `TIME_UNIT_US)
`define HLT_ZERO_UNITS (`HLT_ZERO_MS * 1000 / `TIME_UNIT_US)
`define HLT_STEP_UNITS (`HLT_STEP_US / `TIME_UNIT_US)
`define SRT_SPAN 16
`define RECAL_MAX_STEPS 79
`define RATE_300K_NUM 20
`define RATE_300K_DEN 3
`define REG_MAIN_STATUS 4'h0
`define REG_COMMAND 4'h1
`define REG_NEW_CYL 4'h2
`define REG_SPEC1 4'h3
`define REG_SPEC2 4'h4
`define REG_RATE 4'h5
`define REG_RESULT0 4'h6
`define REG_RESULT1 4'h7
`define REG_RESULT2 4'h8
`define REG_ID_CYL 4'h9
`define REG_ID_HEAD 4'hA
`define REG_ID_SECT 4'hB
`define REG_ID_SIZE 4'hC
`define MSR_RQM_BIT 7
`define MSR_RESULT_BIT 6
`define MSR_NONDMA_BIT 5
`define MSR_BUSY_BIT 4
`define RATE_LOW_POWER_BIT 7
`define ST1_MA_BIT 0
`define ST3_T0_BIT 4
`define ST3_HEAD_BIT 2
`define IC_NORMAL 2'b00
`define IC_ABNORMAL 2'b01
`define IC_INVALID 2'b10
`define IC_POLL 2'b11
`define SPEC1_RST 8'h00
`define SPEC2_RST 8'h00
`define RATE_RST 8'h00
`endif

// File: shared/fdc_ctrl_pkg.sv
// types shared by the control-command block
package fdc_ctrl_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_READ_ID, CMD_RECAL, CMD_SEEK, CMD_SENSE_INT, CMD_SENSE_DRIVE, CMD_SPECIFY
  } cmd_e;
  typedef struct packed {
    logic [1:0] ic;
    logic se;
    logic ec;
    logic nr;
    logic head;
    logic [1:0] ds;
  } st0_s;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
  } id_s;
endpackage

// File: hw/fdc_positioner.sv
// one drive's head positioner: seek and recalibrate step sequencing
`include "fdc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fdc_positioner #(
  parameter int STEP_CYC = `STEP_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic unit_tick,
  input wire logic seek_go,
  input wire logic recal_go,
  input wire logic clear_cyl,
  input wire logic [7:0] target,
  input wire logic [4:0] srt_units,
  input wire logic track_zero,
  // drive and status
  output logic step,
  output logic dir,
  output logic [7:0] present_cyl,
  output logic active,
  output logic done,
  output logic fail
);
  typedef enum logic [1:0] {POS_IDLE, POS_CHECK, POS_PULSE, POS_WAIT} pos_e;
  pos_e state_ff;
  logic recal_ff;
  logic [6:0] steps_ff;
  logic [5:0] pulse_ff;
  logic [4:0] wait_ff;
  logic [7:0] target_ff;

  initial begin
    if (STEP_CYC < 1 || STEP_CYC > 63) $error("STEP_CYC out of range");
  end

  assign active = (state_ff != POS_IDLE);
  assign step = (state_ff == POS_PULSE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= POS_IDLE;
      recal_ff <= 1'b0;
      steps_ff <= 7'h00;
      pulse_ff <= 6'h00;
      wait_ff <= 5'h00;
      target_ff <= 8'h00;
      dir <= 1'b0;
      present_cyl <= 8'h00;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        POS_IDLE: begin
          steps_ff <= 7'h00;
          if (clear_cyl) present_cyl <= 8'h00;
          if (recal_go) begin
            recal_ff <= 1'b1;
            present_cyl <= 8'h00;
            dir <= 1'b0;
            state_ff <= POS_CHECK;
          end else if (seek_go) begin
            recal_ff <= 1'b0;
            target_ff <= target;
            state_ff <= POS_CHECK;
          end
        end
        POS_CHECK: begin
          if (recal_ff) begin
            if (track_zero) begin
              done <= 1'b1;
              fail <= 1'b0;
              state_ff <= POS_IDLE;
            end else if (steps_ff == 7'(`RECAL_MAX_STEPS)) begin
              done <= 1'b1;
              fail <= 1'b1;
              state_ff <= POS_IDLE;
            end else begin
              state_ff <= POS_PULSE;
            end
          end else if (present_cyl == target_ff) begin
            done <= 1'b1;
            fail <= 1'b0;
            state_ff <= POS_IDLE;
          end else begin
            dir <= (present_cyl < target_ff);
            state_ff <= POS_PULSE;
          end
          pulse_ff <= 6'h00;
          // step interval is timed from the rising edge of each pulse
          wait_ff <= 5'h00;
        end
        POS_PULSE: begin
          if (pulse_ff == 6'(STEP_CYC - 1)) begin
            steps_ff <= steps_ff + 7'h01;
            if (!recal_ff) present_cyl <= dir ? present_cyl + 8'h01 : present_cyl - 8'h01;
            state_ff <= POS_WAIT;
          end else begin
            pulse_ff <= pulse_ff + 6'h01;
          end
          if (unit_tick) wait_ff <= wait_ff + 5'h01;
        end
        POS_WAIT: begin
          // the wait starts mid-unit, so the first interval may run short
          if (wait_ff >= srt_units) state_ff <= POS_CHECK;
          else if (unit_tick) wait_ff <= wait_ff + 5'h01;
        end
        default: state_ff <= POS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/fdc_control_commands.sv
// control-command execution: positioning, read id, interrupt sense, specify timing
`include "fdc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - only Read ID, Recalibrate and Seek raise a completion interrupt
// - Read ID latches first ID; none by second index gives code 01, missing mark
// - Recalibrate clears cylinder, steps outward while track zero low, ends with seek end
// - still not at track zero after 79 steps: seek end plus equipment check
// - busy only in command phase; further positioning accepted on up to four drives
// - Seek steps in when present below new cylinder, out when above
// - steps paced by step rate, compare after each, equality sets seek end
// - head bit in positioning status always reads zero
// - leaving low power clears present cylinder of idle drives and stored status
// - interrupt on read id result, positioning end, non-DMA byte request
// - Sense Interrupt Status clears interrupt and reports cause codes
// - drive stays busy until its interrupt is sensed
// - Sense Drive Status goes straight to result with status register three
// - Specify loads head unload, step rate and head load times
// - time codes scale from 2 Mbps values, doubling as rate halves
// - first two step pulses may be closer than the rest
// - non-DMA select picks request-for-master and interrupt, else DMA request
// - equipment check sits in status zero bit 4
module fdc_control_commands #(
  parameter int DRIVES = 4,
  parameter int UNIT_CYC = `UNIT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // drive
  output logic [DRIVES-1:0] STEP_OUT,
  output logic [DRIVES-1:0] DIR_OUT,
  output logic HEAD_LOAD_OUT,
  input wire logic [DRIVES-1:0] TRACK_ZERO_IN,
  input wire logic INDEX_PULSE_IN_N,
  // data path
  input wire logic ID_FOUND,
  input wire fdc_ctrl_pkg::id_s ID_FIELD,
  input wire logic XFER_REQ,
  // host signalling
  output logic CONTROLLER_IRQ_OUT,
  output logic DMA_REQUEST_OUT
);
  typedef enum logic [1:0] {RID_IDLE, RID_LOAD, RID_SEARCH} rid_e;

  initial begin
    if (DRIVES < 1 || DRIVES > 4) $error("DRIVES must be 1 to 4");
    if (UNIT_CYC < 1 || UNIT_CYC * 8 > 1048575) $error("UNIT_CYC out of range");
  end

  // registers and state
  logic [7:0] new_cyl_ff, spec1_ff, spec2_ff, rate_ff;
  logic [3:0] srt_ff, hut_ff;
  logic [6:0] hlt_ff;
  logic nd_ff;
  logic [7:0] res0_ff, res1_ff, res2_ff;
  fdc_ctrl_pkg::id_s id_ff;
  logic result_ff, rid_irq_ff, poll_ff;
  logic [DRIVES-1:0] busy_ff, pend_ff;
  logic [DRIVES-1:0] fail_ff;
  rid_e rid_ff;
  logic [1:0] rid_idx_ff;
  logic rid_ds_head_ff;
  logic [1:0] rid_ds_ff;
  logic head_loaded_ff;
  logic [8:0] head_cnt_ff;
  logic [19:0] unit_cnt_ff;
  logic unit_tick_ff;
  logic irq_ff, dreq_ff;

  // synchronised inputs
  logic [DRIVES-1:0] tz_s1_ff, tz_s2_ff, tz_s3_ff, tz_ff;
  logic ix_s1_ff, ix_s2_ff, ix_s3_ff, ix_ff, ix_prev_ff;

  // positioner wiring
  logic [DRIVES-1:0] seek_go, recal_go, pos_active, pos_done, pos_fail;
  logic [7:0] present_cylinder [DRIVES];

  // decoded strobes
  logic cmd_go, low_power, lp_exit, read_res0, idx_edge;
  fdc_ctrl_pkg::cmd_e opcode;
  logic [1:0] cmd_ds;
  logic cmd_head, ds_ok;
  logic [4:0] srt_units;
  logic [8:0] hut_units, hlt_units;
  logic [19:0] unit_reload;
  logic sense_hit;
  logic [1:0] sense_ds;
  fdc_ctrl_pkg::st0_s sense_st0;

  assign low_power = rate_ff[`RATE_LOW_POWER_BIT];
  assign cmd_go = WR && (ADDR == `REG_COMMAND) && !low_power;
  assign opcode = fdc_ctrl_pkg::cmd_e'(WDATA[7:4]);
  assign cmd_ds = WDATA[1:0];
  assign cmd_head = WDATA[2];
  assign ds_ok = (32'(cmd_ds) < DRIVES);
  assign lp_exit = WR && (ADDR == `REG_RATE) && low_power && !WDATA[`RATE_LOW_POWER_BIT];
  assign read_res0 = RD && (ADDR == `REG_RESULT0);
  assign idx_edge = ix_ff && !ix_prev_ff;

  // step-rate codes count down from the span; zero means the full span
  assign srt_units = 5'(`SRT_SPAN) - {1'b0, srt_ff};
  assign hut_units = (hut_ff == 4'h0) ? 9'(`HUT_ZERO_UNITS) : 9'(hut_ff * `HUT_STEP_UNITS);
  assign hlt_units = (hlt_ff == 7'h00) ? 9'(`HLT_ZERO_UNITS) : 9'(hlt_ff * `HLT_STEP_UNITS);

  // time unit length follows the selected data rate
  always_comb begin
    case (rate_ff[2:0])
      3'h0: unit_reload = 20'(UNIT_CYC);
      3'h1: unit_reload = 20'(UNIT_CYC * 2);
      3'h2: unit_reload = 20'(UNIT_CYC * 4);
      3'h3: unit_reload = 20'(UNIT_CYC * `RATE_300K_NUM / `RATE_300K_DEN);
      default: unit_reload = 20'(UNIT_CYC * 8);
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      unit_cnt_ff <= 20'h00000;
      unit_tick_ff <= 1'b0;
    end else if (unit_cnt_ff + 20'h00001 >= unit_reload) begin
      unit_cnt_ff <= 20'h00000;
      unit_tick_ff <= 1'b1;
    end else begin
      unit_cnt_ff <= unit_cnt_ff + 20'h00001;
      unit_tick_ff <= 1'b0;
    end
  end

  // three-stage synchronisers, a change counts when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < DRIVES; g++) begin : g_drive
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          tz_s1_ff[g] <= 1'b0;
          tz_s2_ff[g] <= 1'b0;
          tz_s3_ff[g] <= 1'b0;
          tz_ff[g] <= 1'b0;
        end else begin
          tz_s1_ff[g] <= TRACK_ZERO_IN[g];
          tz_s2_ff[g] <= tz_s1_ff[g];
          tz_s3_ff[g] <= tz_s2_ff[g];
          if (tz_s2_ff[g] == tz_s3_ff[g]) tz_ff[g] <= tz_s3_ff[g];
        end
      end
      assign seek_go[g] = cmd_go && (opcode == fdc_ctrl_pkg::CMD_SEEK) && ds_ok && (32'(cmd_ds) == g)
                          && !pos_active[g] && !busy_ff[g];
      assign recal_go[g] = cmd_go && (opcode == fdc_ctrl_pkg::CMD_RECAL) && ds_ok && (32'(cmd_ds) == g)
                           && !pos_active[g] && !busy_ff[g];
      fdc_positioner u_pos (
        .clk(CLK),
        .rst_n(RESET_N),
        .unit_tick(unit_tick_ff),
        .seek_go(seek_go[g]),
        .recal_go(recal_go[g]),
        .clear_cyl(lp_exit),
        .target(new_cyl_ff),
        .srt_units(srt_units),
        .track_zero(tz_ff[g]),
        .step(STEP_OUT[g]),
        .dir(DIR_OUT[g]),
        .present_cyl(present_cylinder[g]),
        .active(pos_active[g]),
        .done(pos_done[g]),
        .fail(pos_fail[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ix_s1_ff <= 1'b1;
      ix_s2_ff <= 1'b1;
      ix_s3_ff <= 1'b1;
      ix_ff <= 1'b0;
      ix_prev_ff <= 1'b0;
    end else begin
      ix_s1_ff <= INDEX_PULSE_IN_N;
      ix_s2_ff <= ix_s1_ff;
      ix_s3_ff <= ix_s2_ff;
      if (ix_s2_ff == ix_s3_ff) ix_ff <= !ix_s3_ff;
      ix_prev_ff <= ix_ff;
    end
  end

  // software-written parameter registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      new_cyl_ff <= 8'h00;
      spec1_ff <= `SPEC1_RST;
      spec2_ff <= `SPEC2_RST;
      rate_ff <= `RATE_RST;
    end else if (WR) begin
      if (ADDR == `REG_NEW_CYL) new_cyl_ff <= WDATA;
      if (ADDR == `REG_SPEC1) spec1_ff <= WDATA;
      if (ADDR == `REG_SPEC2) spec2_ff <= WDATA;
      if (ADDR == `REG_RATE) rate_ff <= WDATA;
    end
  end

  // Specify copies the staged timing into the working timers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      srt_ff <= 4'(`SPEC1_RST >> 4);
      hut_ff <= 4'h0;
      hlt_ff <= 7'h00;
      nd_ff <= 1'b0;
    end else if (cmd_go && opcode == fdc_ctrl_pkg::CMD_SPECIFY) begin
      srt_ff <= spec1_ff[7:4];
      hut_ff <= spec1_ff[3:0];
      hlt_ff <= spec2_ff[7:1];
      nd_ff <= spec2_ff[0];
    end
  end

  // lowest pending drive answers Sense Interrupt Status first
  always_comb begin
    sense_hit = 1'b0;
    sense_ds = 2'b00;
    for (int i = DRIVES - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        sense_hit = 1'b1;
        sense_ds = 2'(i);
      end
    end
    sense_st0.ic = fail_ff[sense_ds] ? `IC_ABNORMAL : `IC_NORMAL;
    sense_st0.se = 1'b1;
    sense_st0.ec = fail_ff[sense_ds];
    sense_st0.nr = 1'b0;
    sense_st0.head = 1'b0;
    sense_st0.ds = sense_ds;
    if (!sense_hit) begin
      sense_st0.ic = poll_ff ? `IC_POLL : `IC_INVALID;
      sense_st0.se = 1'b0;
      sense_st0.ec = 1'b0;
      sense_st0.ds = 2'b00;
    end
  end

  // per-drive busy, pending interrupt and termination status
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_ff <= '0;
      pend_ff <= '0;
      fail_ff <= '0;
      poll_ff <= 1'b1;
    end else begin
      for (int i = 0; i < DRIVES; i++) begin
        if (lp_exit) begin
          busy_ff[i] <= 1'b0;
          pend_ff[i] <= 1'b0;
          fail_ff[i] <= 1'b0;
        end else begin
          if (cmd_go && opcode == fdc_ctrl_pkg::CMD_SENSE_INT && sense_hit && 32'(sense_ds) == i) begin
            busy_ff[i] <= 1'b0;
            pend_ff[i] <= 1'b0;
          end
          if (seek_go[i] || recal_go[i]) busy_ff[i] <= 1'b1;
          if (pos_done[i]) begin
            pend_ff[i] <= 1'b1;
            fail_ff[i] <= pos_fail[i];
          end
        end
      end
      if (lp_exit || (cmd_go && opcode == fdc_ctrl_pkg::CMD_SENSE_INT && !sense_hit)) poll_ff <= 1'b0;
    end
  end

  // Read ID sequencing and head load / unload timing
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rid_ff <= RID_IDLE;
      rid_idx_ff <= 2'b00;
      rid_ds_ff <= 2'b00;
      rid_ds_head_ff <= 1'b0;
      head_loaded_ff <= 1'b0;
      head_cnt_ff <= 9'h000;
    end else begin
      case (rid_ff)
        RID_IDLE: begin
          if (cmd_go && opcode == fdc_ctrl_pkg::CMD_READ_ID) begin
            rid_ds_ff <= cmd_ds;
            rid_ds_head_ff <= cmd_head;
            rid_idx_ff <= 2'b00;
            head_cnt_ff <= 9'h000;
            head_loaded_ff <= 1'b1;
            rid_ff <= head_loaded_ff ? RID_SEARCH : RID_LOAD;
          end else if (head_loaded_ff && unit_tick_ff) begin
            if (head_cnt_ff + 9'h001 >= hut_units) begin
              head_loaded_ff <= 1'b0;
              head_cnt_ff <= 9'h000;
            end else begin
              head_cnt_ff <= head_cnt_ff + 9'h001;
            end
          end
        end
        RID_LOAD: begin
          if (unit_tick_ff) begin
            if (head_cnt_ff + 9'h001 >= hlt_units) begin
              head_cnt_ff <= 9'h000;
              rid_ff <= RID_SEARCH;
            end else begin
              head_cnt_ff <= head_cnt_ff + 9'h001;
            end
          end
        end
        RID_SEARCH: begin
          if (ID_FOUND || (idx_edge && rid_idx_ff == 2'b01)) begin
            head_cnt_ff <= 9'h000;
            rid_ff <= RID_IDLE;
          end else if (idx_edge) begin
            rid_idx_ff <= rid_idx_ff + 2'b01;
          end
        end
        default: rid_ff <= RID_IDLE;
      endcase
    end
  end

  // result registers and result-ready flag
  fdc_ctrl_pkg::st0_s rid_st0;
  logic rid_end, rid_miss;
  assign rid_miss = (rid_ff == RID_SEARCH) && !ID_FOUND && idx_edge && (rid_idx_ff == 2'b01);
  assign rid_end = (rid_ff == RID_SEARCH) && (ID_FOUND || rid_miss);
  always_comb begin
    rid_st0.ic = rid_miss ? `IC_ABNORMAL : `IC_NORMAL;
    rid_st0.se = 1'b0;
    rid_st0.ec = 1'b0;
    rid_st0.nr = 1'b0;
    rid_st0.head = rid_ds_head_ff;
    rid_st0.ds = rid_ds_ff;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      res0_ff <= 8'h00;
      res1_ff <= 8'h00;
      res2_ff <= 8'h00;
      id_ff <= '0;
      result_ff <= 1'b0;
      rid_irq_ff <= 1'b0;
    end else if (lp_exit) begin
      res0_ff <= 8'h00;
      res1_ff <= 8'h00;
      res2_ff <= 8'h00;
      result_ff <= 1'b0;
      rid_irq_ff <= 1'b0;
    end else begin
      if (read_res0) begin
        result_ff <= 1'b0;
        rid_irq_ff <= 1'b0;
      end
      if (rid_end) begin
        res0_ff <= rid_st0;
        res2_ff <= 8'(rid_miss) << `ST1_MA_BIT;
        if (ID_FOUND) id_ff <= ID_FIELD;
        result_ff <= 1'b1;
        rid_irq_ff <= 1'b1;
      end else if (cmd_go && opcode == fdc_ctrl_pkg::CMD_SENSE_INT) begin
        res0_ff <= sense_st0;
        res1_ff <= sense_hit ? present_cylinder[sense_ds] : 8'h00;
        result_ff <= 1'b1;
      end else if (cmd_go && opcode == fdc_ctrl_pkg::CMD_SENSE_DRIVE && ds_ok) begin
        res2_ff <= (8'(tz_ff[cmd_ds]) << `ST3_T0_BIT) | (8'(cmd_head) << `ST3_HEAD_BIT) | {6'h00, cmd_ds};
        result_ff <= 1'b1;
      end
    end
  end

  // host signalling: interrupt and DMA request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_ff <= 1'b0;
      dreq_ff <= 1'b0;
    end else begin
      irq_ff <= (|pend_ff) || poll_ff || rid_irq_ff || (nd_ff && XFER_REQ);
      dreq_ff <= !nd_ff && XFER_REQ;
    end
  end
  assign CONTROLLER_IRQ_OUT = irq_ff;
  assign DMA_REQUEST_OUT = dreq_ff;
  assign HEAD_LOAD_OUT = head_loaded_ff;

  // read data, one cycle after the strobe; unmapped addresses read zero
  logic [7:0] msr;
  always_comb begin
    msr = 8'h00;
    msr[DRIVES-1:0] = busy_ff;
    msr[`MSR_BUSY_BIT] = (rid_ff != RID_IDLE);
    msr[`MSR_NONDMA_BIT] = nd_ff && XFER_REQ;
    msr[`MSR_RESULT_BIT] = result_ff;
    msr[`MSR_RQM_BIT] = (rid_ff == RID_IDLE) || (nd_ff && XFER_REQ);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `REG_MAIN_STATUS: RDATA <= msr;
        `REG_NEW_CYL: RDATA <= new_cyl_ff;
        `REG_SPEC1: RDATA <= spec1_ff;
        `REG_SPEC2: RDATA <= spec2_ff;
        `REG_RATE: RDATA <= rate_ff;
        `REG_RESULT0: RDATA <= res0_ff;
        `REG_RESULT1: RDATA <= res1_ff;
        `REG_RESULT2: RDATA <= res2_ff;
        `REG_ID_CYL: RDATA <= id_ff.c;
        `REG_ID_HEAD: RDATA <= id_ff.h;
        `REG_ID_SECT: RDATA <= id_ff.r;
        `REG_ID_SIZE: RDATA <= id_ff.n;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: bench/fdc_control_commands_checker.sv
// port assertions for the control-command block
`include "fdc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fdc_control_commands_checker #(
  parameter int DRIVES = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // drive and transfer
  input wire logic [DRIVES-1:0] STEP_OUT,
  input wire logic [DRIVES-1:0] DIR_OUT,
  input wire logic XFER_REQ,
  input wire logic DMA_REQUEST_OUT
);
  localparam int PULSE_LAST = `STEP_PULSE_CYC - 1;
  logic [7:0] steps_ff;
  logic recal_ff, sense_ff, step0_ff;
  logic cmd_wr, res0_rd;
  assign cmd_wr = WR && ADDR == `REG_COMMAND;
  assign res0_rd = RD && ADDR == `REG_RESULT0 && sense_ff;
  // drive 0 step count since its last command
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      steps_ff <= 8'h00;
      recal_ff <= 1'b0;
      step0_ff <= 1'b0;
    end else begin
      step0_ff <= STEP_OUT[0];
      if (cmd_wr && WDATA[1:0] == 2'h0) begin
        steps_ff <= 8'h00;
        recal_ff <= WDATA[7:4] == 4'h2;
      end else if (STEP_OUT[0] && !step0_ff) begin
        steps_ff <= steps_ff + 8'h01;
      end
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sense_ff <= 1'b0;
    end else if (cmd_wr) begin
      sense_ff <= WDATA[7:4] == 4'h4;
    end else if (WR && ADDR == `REG_RATE) begin
      sense_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_step_width: assert property ($rose(STEP_OUT[0]) |-> ##PULSE_LAST STEP_OUT[0] ##1 !STEP_OUT[0])
    else $error("step pulse width wrong");
  a_dir_steady: assert property (((DIR_OUT ^ $past(DIR_OUT)) & STEP_OUT & $past(STEP_OUT)) == '0)
    else $error("direction moved during a step");
  a_dma_cause: assert property (DMA_REQUEST_OUT |-> $past(XFER_REQ))
    else $error("dma request without transfer need");
  a_recal_limit: assert property (recal_ff |-> steps_ff <= 8'h4F)
    else $error("recalibrate stepped too often");
  a_recal_out: assert property (recal_ff && STEP_OUT[0] |-> !DIR_OUT[0])
    else $error("recalibrate stepped inward");
  a_head_zero: assert property (res0_rd |=> !RDATA[2])
    else $error("head bit set in sense status");
  a_se_code: assert property (res0_rd |=> RDATA[5] == !RDATA[7])
    else $error("seek end does not match code");
  a_ec_abnormal: assert property (res0_rd |=> !RDATA[4] || RDATA[7:6] == 2'h1)
    else $error("equipment check on normal end");
endmodule
`default_nettype wire

// File: bench/fdc_drive_model.sv
// floppy drive model: head position per drive, track zero and index pulses
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model #(
  parameter int DRIVES = 4,
  parameter int INDEX_CYC = 400
) (
  // clock
  input wire logic clk,
  // heads
  input wire logic [DRIVES-1:0] step,
  input wire logic [DRIVES-1:0] dir,
  output logic [DRIVES-1:0] track_zero,
  output logic index_n
);
  int pos [DRIVES];
  int icnt;
  logic [DRIVES-1:0] step_q;
  initial begin
    foreach (pos[i]) pos[i] = 0;
    pos[0] = 3;
    pos[1] = 100;
    icnt = 0;
    step_q = '0;
  end
  // one track per rising step; the head stops at track zero
  always @(posedge clk) begin
    step_q <= step;
    icnt <= (icnt + 1) % INDEX_CYC;
    for (int i = 0; i < DRIVES; i++) begin
      if (step[i] && !step_q[i]) begin
        pos[i] <= dir[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < DRIVES; i++) begin
      track_zero[i] = pos[i] == 0;
    end
    index_n = icnt >= 4;
  end
endmodule
`default_nettype wire

// File: bench/test_fdc_control_commands.sv
// self-checking bench for the control-command block
`include "fdc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_fdc_control_commands;
  logic CLK, RESET_N, WR, RD, ID_FOUND, XFER_REQ, HEAD_LOAD_OUT, INDEX_PULSE_IN_N, CONTROLLER_IRQ_OUT, DMA_REQUEST_OUT;
  logic [3:0] ADDR, STEP_OUT, DIR_OUT, TRACK_ZERO_IN;
  logic [7:0] WDATA, RDATA, d;
  fdc_ctrl_pkg::id_s ID_FIELD;
  int bad_count, samples_checked;
  fdc_control_commands #(.DRIVES(4), .UNIT_CYC(4)) dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT), .HEAD_LOAD_OUT(HEAD_LOAD_OUT),
    .TRACK_ZERO_IN(TRACK_ZERO_IN), .INDEX_PULSE_IN_N(INDEX_PULSE_IN_N), .ID_FOUND(ID_FOUND), .ID_FIELD(ID_FIELD),
    .XFER_REQ(XFER_REQ), .CONTROLLER_IRQ_OUT(CONTROLLER_IRQ_OUT), .DMA_REQUEST_OUT(DMA_REQUEST_OUT));
  fdc_drive_model #(.DRIVES(4)) drv (.clk(CLK), .step(STEP_OUT), .dir(DIR_OUT), .track_zero(TRACK_ZERO_IN),
    .index_n(INDEX_PULSE_IN_N));
  always #10 CLK = ~CLK;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic sense(input logic [7:0] st, input logic [7:0] cyl);
    wr(`REG_COMMAND, 8'h40);
    rd(`REG_RESULT0);
    chk(d, st);
    rd(`REG_RESULT1);
    chk(d, cyl);
  endtask
  task automatic wirq;
    for (int n = 0; n < 9000 && CONTROLLER_IRQ_OUT !== 1'b1; n++) @(posedge CLK);
    chk({7'h00, CONTROLLER_IRQ_OUT}, 8'h01);
  endtask
  task automatic seekm(input logic [7:0] cyl, input logic [7:0] cmd, input logic [7:0] gap, input logic dir);
    time t;
    wr(`REG_NEW_CYL, cyl);
    wr(`REG_COMMAND, cmd);
    @(posedge STEP_OUT[0]);
    @(posedge STEP_OUT[0]);
    t = $time;
    @(posedge STEP_OUT[0]);
    chk(8'(($time - t) / 20), gap);
    chk({7'h00, DIR_OUT[0]}, {7'h00, dir});
    wirq();
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge CLK);
    bad_count++;
    conclude();
  end
  initial begin
    {CLK, RESET_N, WR, RD, ID_FOUND, XFER_REQ, ADDR, WDATA, ID_FIELD} = '0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    wirq();
    sense(8'hC0, 8'h00);
    rd(4'hF);
    chk(d, 8'h00);
    wr(`REG_SPEC1, 8'h20);
    wr(`REG_SPEC2, 8'h06);
    wr(`REG_COMMAND, 8'h60);
    wr(`REG_COMMAND, 8'h50);
    rd(`REG_RESULT2);
    chk(d, 8'h00);
    chk({7'h00, CONTROLLER_IRQ_OUT}, 8'h00);
    wr(`REG_COMMAND, 8'h20);
    rd(`REG_MAIN_STATUS);
    chk({3'h0, d[4:0]}, 8'h01);
    wr(`REG_COMMAND, 8'h22);
    repeat (400) @(posedge CLK);
    chk({7'h00, TRACK_ZERO_IN[0]}, 8'h01);
    sense(8'h20, 8'h00);
    sense(8'h22, 8'h00);
    seekm(8'h05, 8'h30, 8'h38, 1'b1);
    sense(8'h20, 8'h05);
    wr(`REG_RATE, 8'h01);
    seekm(8'h02, 8'h34, 8'h70, 1'b0);
    sense(8'h20, 8'h02);
    wr(`REG_NEW_CYL, 8'h07);
    wr(`REG_COMMAND, 8'h30);
    repeat (1500) @(posedge CLK);
    wr(`REG_NEW_CYL, 8'h09);
    wr(`REG_COMMAND, 8'h30);
    repeat (1500) @(posedge CLK);
    sense(8'h20, 8'h07);
    wr(`REG_RATE, 8'h00);
    wr(`REG_COMMAND, 8'h21);
    wirq();
    sense(8'h71, 8'h00);
    chk(8'(drv.pos[1]), 8'h15);
    wr(`REG_COMMAND, 8'h10);
    repeat (100) @(posedge CLK);
    ID_FOUND <= 1'b1;
    ID_FIELD <= {8'h07, 8'h00, 8'h03, 8'h02};
    @(posedge CLK);
    ID_FOUND <= 1'b0;
    wirq();
    rd(`REG_RESULT0);
    chk(d, 8'h00);
    rd(`REG_ID_CYL);
    chk(d, 8'h07);
    rd(`REG_ID_SECT);
    chk(d, 8'h03);
    wr(`REG_COMMAND, 8'h10);
    wirq();
    rd(`REG_RESULT0);
    chk(d, 8'h40);
    rd(`REG_RESULT2);
    chk(d, 8'h01);
    XFER_REQ <= 1'b1;
    @(posedge CLK);
    #1 chk({7'h00, DMA_REQUEST_OUT}, 8'h01);
    XFER_REQ <= 1'b0;
    wr(`REG_SPEC2, 8'h07);
    wr(`REG_COMMAND, 8'h60);
    XFER_REQ <= 1'b1;
    rd(`REG_MAIN_STATUS);
    chk({7'h00, d[5]}, 8'h01);
    chk({6'h00, CONTROLLER_IRQ_OUT, DMA_REQUEST_OUT}, 8'h02);
    XFER_REQ <= 1'b0;
    wr(`REG_NEW_CYL, 8'h03);
    wr(`REG_COMMAND, 8'h30);
    repeat (600) @(posedge CLK);
    wr(`REG_RATE, 8'h80);
    wr(`REG_RATE, 8'h00);
    rd(`REG_RESULT1);
    chk(d, 8'h00);
    wr(`REG_COMMAND, 8'h40);
    rd(`REG_RESULT0);
    chk(d, 8'h80);
    conclude();
  end
endmodule
bind fdc_control_commands fdc_control_commands_checker #(.DRIVES(DRIVES)) chk_i (.CLK(CLK), .RESET_N(RESET_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT),
  .XFER_REQ(XFER_REQ), .DMA_REQUEST_OUT(DMA_REQUEST_OUT));
`default_nettype wire
